// ==== shared/ccc_pkg.sv ====
// Purpose: shared constants for the control channel configuration bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register indices are kept; byte address is four times the index
package ccc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_SETUP = 8'h32;
  localparam logic [7:0] IDX_DPATH = 8'h33;
  localparam logic [7:0] IDX_CAPS = 8'h35;
  localparam logic [7:0] IDX_IDENT = 8'h37;
  localparam logic [7:0] IDX_TARGET0 = 8'h39;
  localparam logic [7:0] IDX_ALIAS0 = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  // control_channel_setup fields
  localparam int SETUP_PASS_ALL = 7;
  localparam int SETUP_PASS_DECODE = 6;
  localparam int SETUP_AUTO_ACK = 5;
  localparam int SETUP_PARITY_ON = 3;
  localparam logic [7:0] SETUP_RST = 8'h09;
  // datapath_control_one fields
  localparam int DPATH_CRC_ON = 2;
  localparam int DPATH_GPIO_HI = 1;
  localparam int DPATH_GPIO_LO = 0;
  localparam logic [7:0] DPATH_RST = 8'h04;
  // partner_capabilities fields
  localparam int CAPS_HOLD = 7;
  localparam int CAPS_SELF_TEST = 5;
  localparam int CAPS_MULTI_PORT = 4;
  localparam int CAPS_PORT_HI = 3;
  localparam int CAPS_PORT_LO = 0;
  localparam logic [7:0] CAPS_RST = 8'h00;
  // partner_identifier fields
  localparam int IDENT_HI = 7;
  localparam int IDENT_LO = 1;
  localparam int IDENT_HOLD = 0;
  // arbitrary neutral identifier reset value
  localparam logic [6:0] IDENT_VALUE_RST = 7'h2A;
  localparam logic [7:0] TARGET_RST = 8'h00;
  localparam logic [7:0] ALIAS_RST = 8'h00;
  // status fields (parity error is write one to clear; link follows bc_link_detect)
  localparam int STAT_PARITY_ERR = 0;
  localparam int STAT_LINK = 1;
  // control sequence
  localparam int SEQ_CRC_BYTES = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  // forward gpio count encodings
  localparam logic [1:0] GPIO_NONE = 2'h0;
  localparam logic [1:0] GPIO_ONE = 2'h1;
  localparam logic [1:0] GPIO_TWO = 2'h2;
  localparam logic [1:0] GPIO_FOUR = 2'h3;
endpackage : ccc_pkg

// ==== shared/ccc_cfg_if.sv ====
// Purpose: pass-through policy handed from the register bank to the i2c gate
// Assumes: single clock domain
// Notes: bank drives, gate reads
`timescale 1ns/1ps
`default_nettype none
interface ccc_cfg_if;
  logic pass_all;
  logic pass_decode;
  logic auto_ack;
  logic [6:0] alias_addr;
  logic [6:0] target_addr;
  modport bank (output pass_all, output pass_decode, output auto_ack,
                output alias_addr, output target_addr);
  modport gate (input pass_all, input pass_decode, input auto_ack,
                input alias_addr, input target_addr);
endinterface : ccc_cfg_if
`default_nettype wire

// ==== rtl/ccc_i2c_gate.sv ====
// Purpose: decides forwarding, address remap and local acknowledge per i2c transaction
// Assumes: request is a one-cycle pulse from the local i2c target logic
// Notes: results are registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module ccc_i2c_gate (
  input wire logic pclk,
  input wire logic presetn,
  ccc_cfg_if.gate cfg,
  input wire logic req_valid,
  input wire logic [6:0] req_addr,
  input wire logic req_write,
  input wire logic remote_ack,
  input wire logic fwd_lock,
  output logic fwd_valid_ff,
  output logic [6:0] fwd_addr_ff,
  output logic ack_valid_ff,
  output logic ack_ff
);
  logic alias_hit;
  logic nxt_fwd;
  logic [6:0] nxt_addr;

  assign alias_hit = (cfg.alias_addr != 7'h00) && (req_addr == cfg.alias_addr);

  always_comb begin
    nxt_fwd = cfg.pass_all;
    if (cfg.pass_decode && alias_hit) begin
      nxt_fwd = 1'b1;
    end
    nxt_addr = alias_hit ? cfg.target_addr : req_addr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid_ff <= 1'b0;
      fwd_addr_ff <= 7'h00;
    end else begin
      fwd_valid_ff <= req_valid && nxt_fwd;
      if (req_valid) begin
        fwd_addr_ff <= nxt_addr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_valid_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      ack_valid_ff <= req_valid;
      if (req_valid) begin
        if (req_write && cfg.auto_ack) begin
          ack_ff <= 1'b1;
        end else begin
          ack_ff <= fwd_lock && remote_ack;
        end
      end
    end
  end
endmodule : ccc_i2c_gate
`default_nettype wire

// ==== rtl/ccc_regs.sv ====
// Purpose: control channel configuration and partner status register bank
// Assumes: APB slave, one wait state; link-side inputs are on pclk
// Notes: partner fields load from the back channel unless held by software
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pass-all bit forwards every i2c transaction
// - decode pass-through forwards only matching addresses
// - auto-ack acknowledges writes unconditionally
// - parity check on back channel when enabled
// - crc over 8 sequence bytes, sent ninth
// - gpio count field: none, one, two, four
// - link detect loads partner capability fields
// - capability hold blocks automatic loading
// - self-test bit mirrors partner request
// - multi-port bit: 0 single, 1 multi
// - identifier loads from remote deserializer
// - identifier hold keeps software value
// - alias address remapped to physical target
module ccc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bc_link_detect,
  input wire logic cap_load,
  input wire logic cap_self_test,
  input wire logic cap_multi_port,
  input wire logic [3:0] cap_port_num,
  input wire logic ident_load,
  input wire logic [6:0] ident_value,
  input wire logic bc_rx_valid,
  input wire logic [7:0] bc_rx_data,
  input wire logic bc_rx_parity,
  output logic parity_err_pulse,
  input wire logic seq_valid,
  input wire logic seq_first,
  input wire logic [7:0] seq_byte,
  output logic crc_valid,
  output logic [7:0] crc_byte,
  output logic [2:0] fwd_gpio_lanes,
  input wire logic i2c_req_valid,
  input wire logic [6:0] i2c_req_addr,
  input wire logic i2c_req_write,
  input wire logic remote_ack,
  input wire logic fwd_lock,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic i2c_ack_valid,
  output logic i2c_ack
);
  logic [7:0] setup_ff;
  logic [7:0] dpath_ff;
  logic [7:0] caps_ff;
  logic [7:0] ident_ff;
  logic [7:0] target_ff;
  logic [7:0] alias_ff;
  logic [1:0] status_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic perr_ff;
  logic crc_valid_ff;
  logic [7:0] crc_byte_ff;
  logic [7:0] crc_acc_ff;
  logic [3:0] seq_cnt_ff;
  logic [2:0] gpio_lanes_ff;
  logic access;
  logic wr_en;
  logic addr_ok;
  logic [7:0] idx;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;
  logic caps_held;
  logic rx_parity_bad;
  logic [7:0] nxt_crc;
  logic [3:0] nxt_cnt;

  ccc_cfg_if cfg_bus ();

  function automatic logic [7:0] crc8_step(input logic [7:0] acc, input logic [7:0] din);
    logic [7:0] c;
    c = acc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ ccc_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_step

  function automatic logic [2:0] gpio_lanes(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h0;
    unique case (code)
      ccc_pkg::GPIO_NONE: n = 3'h0;
      ccc_pkg::GPIO_ONE: n = 3'h1;
      ccc_pkg::GPIO_TWO: n = 3'h2;
      ccc_pkg::GPIO_FOUR: n = 3'h4;
    endcase
    return n;
  endfunction : gpio_lanes

  // apb decode: word index from byte address, low bits must be zero
  assign idx = paddr[9:2];
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready_ff && addr_ok;
  always_comb begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr[ccc_pkg::ADDR_W-1:10] == '0);
    unique case (idx)
      ccc_pkg::IDX_SETUP, ccc_pkg::IDX_DPATH, ccc_pkg::IDX_CAPS, ccc_pkg::IDX_IDENT,
      ccc_pkg::IDX_TARGET0, ccc_pkg::IDX_ALIAS0, ccc_pkg::IDX_STATUS: ;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = !addr_ok;
    if (addr_ok) begin
      unique case (idx)
        ccc_pkg::IDX_SETUP: nxt_prdata[7:0] = setup_ff;
        ccc_pkg::IDX_DPATH: nxt_prdata[7:0] = dpath_ff;
        ccc_pkg::IDX_CAPS: nxt_prdata[7:0] = caps_ff;
        ccc_pkg::IDX_IDENT: nxt_prdata[7:0] = ident_ff;
        ccc_pkg::IDX_TARGET0: nxt_prdata[7:0] = {target_ff[7:1], 1'b0};
        ccc_pkg::IDX_ALIAS0: nxt_prdata[7:0] = {alias_ff[7:1], 1'b0};
        ccc_pkg::IDX_STATUS: nxt_prdata[1:0] = status_ff;
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && nxt_slverr;
      if (access && !pready_ff && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // plain configuration registers; reserved bits are stored as written, except bit 0 of target and alias, which is stored as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ff <= ccc_pkg::SETUP_RST;
      dpath_ff <= ccc_pkg::DPATH_RST;
      target_ff <= ccc_pkg::TARGET_RST;
      alias_ff <= ccc_pkg::ALIAS_RST;
    end else if (wr_en) begin
      unique case (idx)
        ccc_pkg::IDX_SETUP: setup_ff <= pwdata[7:0];
        ccc_pkg::IDX_DPATH: dpath_ff <= pwdata[7:0];
        ccc_pkg::IDX_TARGET0: target_ff <= {pwdata[7:1], 1'b0};
        ccc_pkg::IDX_ALIAS0: alias_ff <= {pwdata[7:1], 1'b0};
        default: ;
      endcase
    end
  end

  // capability hold taken from the write in flight so a write that sets it is kept
  assign caps_held = (wr_en && idx == ccc_pkg::IDX_CAPS) ? pwdata[ccc_pkg::CAPS_HOLD]
                                                      : caps_ff[ccc_pkg::CAPS_HOLD];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caps_ff <= ccc_pkg::CAPS_RST;
    end else begin
      if (wr_en && idx == ccc_pkg::IDX_CAPS) begin
        caps_ff <= pwdata[7:0];
      end
      if (bc_link_detect && cap_load && !caps_held) begin
        caps_ff[ccc_pkg::CAPS_SELF_TEST] <= cap_self_test;
        caps_ff[ccc_pkg::CAPS_MULTI_PORT] <= cap_multi_port;
        caps_ff[ccc_pkg::CAPS_PORT_HI:ccc_pkg::CAPS_PORT_LO] <= cap_port_num;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_ff <= {ccc_pkg::IDENT_VALUE_RST, 1'b0};
    end else begin
      if (wr_en && idx == ccc_pkg::IDX_IDENT) begin
        ident_ff <= pwdata[7:0];
      end else if (ident_load && bc_link_detect && !ident_ff[ccc_pkg::IDENT_HOLD]) begin
        ident_ff[ccc_pkg::IDENT_HI:ccc_pkg::IDENT_LO] <= ident_value;
      end
    end
  end

  // back-channel parity, even parity over data plus parity bit
  assign rx_parity_bad = bc_rx_valid && setup_ff[ccc_pkg::SETUP_PARITY_ON]
                         && ((^bc_rx_data) != bc_rx_parity);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_ff <= 1'b0;
    end else begin
      perr_ff <= rx_parity_bad;
    end
  end

  // status: sticky parity error and link state; a new error beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 2'h0;
    end else begin
      status_ff[ccc_pkg::STAT_LINK] <= bc_link_detect;
      if (rx_parity_bad) begin
        status_ff[ccc_pkg::STAT_PARITY_ERR] <= 1'b1;
      end else if (wr_en && idx == ccc_pkg::IDX_STATUS && pwdata[ccc_pkg::STAT_PARITY_ERR]) begin
        status_ff[ccc_pkg::STAT_PARITY_ERR] <= 1'b0;
      end
    end
  end

  // control sequence crc: first byte restarts, eighth byte releases crc
  always_comb begin
    nxt_crc = crc8_step(seq_first ? ccc_pkg::CRC_INIT : crc_acc_ff, seq_byte);
    nxt_cnt = seq_first ? 4'h1 : (seq_cnt_ff + 4'h1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_acc_ff <= ccc_pkg::CRC_INIT;
      seq_cnt_ff <= 4'h0;
      crc_valid_ff <= 1'b0;
      crc_byte_ff <= 8'h00;
    end else begin
      crc_valid_ff <= 1'b0;
      if (seq_valid && (seq_first || seq_cnt_ff < 4'(ccc_pkg::SEQ_CRC_BYTES))) begin
        crc_acc_ff <= nxt_crc;
        seq_cnt_ff <= nxt_cnt;
        if (nxt_cnt == 4'(ccc_pkg::SEQ_CRC_BYTES) && dpath_ff[ccc_pkg::DPATH_CRC_ON]) begin
          crc_valid_ff <= 1'b1;
          crc_byte_ff <= nxt_crc;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_lanes_ff <= 3'h0;
    end else begin
      gpio_lanes_ff <= gpio_lanes(dpath_ff[ccc_pkg::DPATH_GPIO_HI:ccc_pkg::DPATH_GPIO_LO]);
    end
  end

  assign cfg_bus.pass_all = setup_ff[ccc_pkg::SETUP_PASS_ALL];
  assign cfg_bus.pass_decode = setup_ff[ccc_pkg::SETUP_PASS_DECODE];
  assign cfg_bus.auto_ack = setup_ff[ccc_pkg::SETUP_AUTO_ACK];
  assign cfg_bus.alias_addr = alias_ff[7:1];
  assign cfg_bus.target_addr = target_ff[7:1];

  ccc_i2c_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_bus.gate),
    .req_valid(i2c_req_valid),
    .req_addr(i2c_req_addr),
    .req_write(i2c_req_write),
    .remote_ack(remote_ack),
    .fwd_lock(fwd_lock),
    .fwd_valid_ff(fwd_valid),
    .fwd_addr_ff(fwd_addr),
    .ack_valid_ff(i2c_ack_valid),
    .ack_ff(i2c_ack)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign parity_err_pulse = perr_ff;
  assign crc_valid = crc_valid_ff;
  assign crc_byte = crc_byte_ff;
  assign fwd_gpio_lanes = gpio_lanes_ff;
endmodule : ccc_regs
`default_nettype wire

// ==== tb/ccc_regs_assertions.sv ====
// Purpose: port-level checks for the configuration bank
// Assumes: one pclk domain, async active-low reset
// Notes: bound to the bank from the testbench top
`timescale 1ns/1ps
`default_nettype none
module ccc_regs_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic i2c_req_valid,
  input wire logic i2c_req_write,
  input wire logic fwd_lock,
  input wire logic remote_ack,
  input wire logic fwd_valid,
  input wire logic i2c_ack_valid,
  input wire logic i2c_ack,
  input wire logic bc_rx_valid,
  input wire logic [7:0] bc_rx_data,
  input wire logic bc_rx_parity,
  input wire logic parity_err_pulse,
  input wire logic seq_valid,
  input wire logic crc_valid,
  input wire logic [2:0] fwd_gpio_lanes
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fwd_cause: assert property (fwd_valid |-> $past(i2c_req_valid))
    else $error("forward without request");
  a_ack_follow: assert property (i2c_req_valid |=> i2c_ack_valid)
    else $error("no ack decision after request");
  a_ack_remote: assert property (i2c_ack_valid && !$past(i2c_req_write) |->
    i2c_ack == ($past(fwd_lock) && $past(remote_ack)))
    else $error("read ack not from lock and remote");
  a_parity_cause: assert property (parity_err_pulse |-> $past(bc_rx_valid) &&
    (^$past(bc_rx_data) != $past(bc_rx_parity)))
    else $error("parity error without bad byte");
  a_crc_cause: assert property (crc_valid |-> $past(seq_valid))
    else $error("crc without sequence byte");
  a_crc_single: assert property (crc_valid |=> !crc_valid)
    else $error("crc pulse too long");
  a_gpio_code: assert property (fwd_gpio_lanes inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("illegal gpio lane count");
  c_fwd: cover property (fwd_valid);
  c_crc: cover property (crc_valid);
  c_par: cover property (parity_err_pulse);
endmodule : ccc_regs_assertions
`default_nettype wire

// ==== tb/ccc_far_model.sv ====
// Purpose: behavioural companion deserializer on the back channel
// Assumes: link side runs on pclk
// Notes: data lines show the inverse of the last value when idle
`timescale 1ns/1ps
`default_nettype none
module ccc_far_model (
  input wire logic pclk,
  output logic bc_link_detect,
  output logic cap_load,
  output logic cap_self_test,
  output logic cap_multi_port,
  output logic [3:0] cap_port_num,
  output logic ident_load,
  output logic [6:0] ident_value,
  output logic bc_rx_valid,
  output logic [7:0] bc_rx_data,
  output logic bc_rx_parity
);
  initial {bc_link_detect, cap_load, cap_self_test, cap_multi_port, cap_port_num} = '0;
  initial {ident_load, ident_value, bc_rx_valid, bc_rx_data, bc_rx_parity} = '0;
  task automatic send_caps(input logic s, input logic m, input logic [3:0] p);
    @(posedge pclk);
    {bc_link_detect, cap_load, cap_self_test, cap_multi_port, cap_port_num} <= {2'h3, s, m, p};
    @(posedge pclk);
    {cap_load, cap_self_test, cap_multi_port, cap_port_num} <= {1'b0, ~{s, m, p}};
  endtask : send_caps
  task automatic send_ident(input logic [6:0] v);
    @(posedge pclk);
    {ident_load, ident_value} <= {1'b1, v};
    @(posedge pclk);
    {ident_load, ident_value} <= {1'b0, ~v};
  endtask : send_ident
  // even parity; bad flips it
  task automatic send_byte(input logic [7:0] d, input logic bad);
    @(posedge pclk);
    {bc_rx_valid, bc_rx_data, bc_rx_parity} <= {1'b1, d, (^d) ^ bad};
    @(posedge pclk);
    {bc_rx_valid, bc_rx_data} <= {1'b0, ~d};
  endtask : send_byte
endmodule : ccc_far_model
`default_nettype wire

// ==== tb/ccc_regs_tb_top.sv ====
// Purpose: self-checking bench for the configuration bank
// Assumes: one wait state apb slave, far model drives the link side
// Notes: byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
module ccc_regs_tb_top;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, seq_valid = 0, seq_first = 0;
  logic i2c_req_valid = 0, i2c_req_write = 0, remote_ack = 0, fwd_lock = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] seq_byte = '0;
  logic [6:0] i2c_req_addr = '0;
  wire logic pready, pslverr, parity_err_pulse, crc_valid, fwd_valid, i2c_ack_valid, i2c_ack;
  wire logic bc_link_detect, cap_load, cap_self_test, cap_multi_port, ident_load;
  wire logic bc_rx_valid, bc_rx_parity;
  wire logic [31:0] prdata;
  wire logic [7:0] crc_byte, bc_rx_data;
  wire logic [6:0] fwd_addr, ident_value;
  wire logic [3:0] cap_port_num;
  wire logic [2:0] fwd_gpio_lanes;
  int compares = 0;
  int miscompares = 0;
  always #25 pclk = ~pclk;
  ccc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bc_link_detect(bc_link_detect), .cap_load(cap_load),
    .cap_self_test(cap_self_test), .cap_multi_port(cap_multi_port),
    .cap_port_num(cap_port_num), .ident_load(ident_load), .ident_value(ident_value),
    .bc_rx_valid(bc_rx_valid), .bc_rx_data(bc_rx_data), .bc_rx_parity(bc_rx_parity),
    .parity_err_pulse(parity_err_pulse), .seq_valid(seq_valid), .seq_first(seq_first),
    .seq_byte(seq_byte), .crc_valid(crc_valid), .crc_byte(crc_byte),
    .fwd_gpio_lanes(fwd_gpio_lanes), .i2c_req_valid(i2c_req_valid),
    .i2c_req_addr(i2c_req_addr), .i2c_req_write(i2c_req_write), .remote_ack(remote_ack),
    .fwd_lock(fwd_lock), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .i2c_ack_valid(i2c_ack_valid), .i2c_ack(i2c_ack));
  ccc_far_model u_far (.pclk(pclk), .bc_link_detect(bc_link_detect), .cap_load(cap_load),
    .cap_self_test(cap_self_test), .cap_multi_port(cap_multi_port),
    .cap_port_num(cap_port_num), .ident_load(ident_load), .ident_value(ident_value),
    .bc_rx_valid(bc_rx_valid), .bc_rx_data(bc_rx_data), .bc_rx_parity(bc_rx_parity));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic [31:0] r, output logic s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, 2'h0, i, 2'h0, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    s = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic s;
    apb(1'b1, i, d, r, s);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] i, input logic [7:0] e);
    logic [31:0] r;
    logic s;
    apb(1'b0, i, 8'h00, r, s);
    chk(n, {24'h0, e}, r);
  endtask : rd
  task automatic req(input logic [6:0] a, input logic w);
    @(posedge pclk);
    {i2c_req_valid, i2c_req_addr, i2c_req_write} <= {1'b1, a, w};
    @(posedge pclk);
    i2c_req_valid <= 1'b0;
    #1;
  endtask : req
  task automatic t_reset;
    logic [31:0] r;
    logic s;
    rd("setup", ccc_pkg::IDX_SETUP, 8'h09);
    rd("datapath", ccc_pkg::IDX_DPATH, 8'h04);
    rd("caps", ccc_pkg::IDX_CAPS, 8'h00);
    rd("ident", ccc_pkg::IDX_IDENT, {ccc_pkg::IDENT_VALUE_RST, 1'b0});
    apb(1'b0, 8'h38, 8'h00, r, s);
    chk("slverr", 32'h1, 32'(s));
    chk("unmapped", 32'h0, r);
  endtask : t_reset
  task automatic t_gpio;
    logic [2:0] lanes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    for (int i = 0; i < 4; i++) begin
      wr(ccc_pkg::IDX_DPATH, 8'h04 | 8'(i));
      repeat (2) @(posedge pclk);
      #1 chk("lanes", 32'(lanes[i]), 32'(fwd_gpio_lanes));
    end
  endtask : t_gpio
  task automatic t_partner;
    u_far.send_caps(1'b1, 1'b1, 4'h5);
    rd("caps load", ccc_pkg::IDX_CAPS, 8'h35);
    wr(ccc_pkg::IDX_CAPS, 8'h83);
    u_far.send_caps(1'b0, 1'b0, 4'hA);
    rd("caps held", ccc_pkg::IDX_CAPS, 8'h83);
    wr(ccc_pkg::IDX_CAPS, 8'h00);
    u_far.send_caps(1'b0, 1'b1, 4'h9);
    rd("caps reload", ccc_pkg::IDX_CAPS, 8'h19);
    u_far.send_ident(7'h11);
    rd("ident load", ccc_pkg::IDX_IDENT, 8'h22);
    wr(ccc_pkg::IDX_IDENT, 8'h07);
    u_far.send_ident(7'h55);
    rd("ident held", ccc_pkg::IDX_IDENT, 8'h07);
  endtask : t_partner
  task automatic t_parity;
    u_far.send_byte(8'h5A, 1'b1);
    #1 chk("parity bad", 32'h1, 32'(parity_err_pulse));
    rd("status set", ccc_pkg::IDX_STATUS, 8'h03);
    wr(ccc_pkg::IDX_STATUS, 8'h01);
    rd("status clear", ccc_pkg::IDX_STATUS, 8'h02);
    u_far.send_byte(8'h5A, 1'b0);
    #1 chk("parity good", 32'h0, 32'(parity_err_pulse));
    wr(ccc_pkg::IDX_SETUP, 8'h01);
    u_far.send_byte(8'h3C, 1'b1);
    #1 chk("parity off", 32'h0, 32'(parity_err_pulse));
  endtask : t_parity
  task automatic t_crc(input logic en);
    logic [7:0] c = 8'hFF;
    logic [7:0] b = 8'h05;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      {seq_valid, seq_first, seq_byte} <= {1'b1, i == 0, b};
      c ^= b;
      for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      b += 8'h1D;
    end
    @(posedge pclk);
    seq_valid <= 1'b0;
    #1 chk("crc valid", 32'(en), 32'(crc_valid));
    if (en) chk("crc byte", 32'(c), 32'(crc_byte));
  endtask : t_crc
  task automatic t_i2c;
    wr(ccc_pkg::IDX_TARGET0, 8'hA0);
    wr(ccc_pkg::IDX_ALIAS0, 8'h40);
    wr(ccc_pkg::IDX_SETUP, 8'h49);
    req(7'h20, 1'b0);
    chk("fwd alias", 32'h1, 32'(fwd_valid));
    chk("fwd remap", 32'h50, 32'(fwd_addr));
    req(7'h21, 1'b0);
    chk("fwd nomatch", 32'h0, 32'(fwd_valid));
    wr(ccc_pkg::IDX_SETUP, 8'h89);
    req(7'h21, 1'b0);
    chk("fwd all", 32'h1, 32'(fwd_valid));
    chk("fwd addr", 32'h21, 32'(fwd_addr));
    wr(ccc_pkg::IDX_SETUP, 8'h29);
    req(7'h21, 1'b1);
    chk("auto ack", 32'h1, 32'(i2c_ack));
    chk("ack valid", 32'h1, 32'(i2c_ack_valid));
    chk("fwd off", 32'h0, 32'(fwd_valid));
    wr(ccc_pkg::IDX_SETUP, 8'h09);
    req(7'h21, 1'b1);
    chk("no ack", 32'h0, 32'(i2c_ack));
    @(posedge pclk);
    {fwd_lock, remote_ack} <= 2'h3;
    req(7'h21, 1'b0);
    chk("remote ack", 32'h1, 32'(i2c_ack));
  endtask : t_i2c
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gpio;
    t_partner;
    t_parity;
    t_crc(1'b1);
    wr(ccc_pkg::IDX_DPATH, 8'h00);
    t_crc(1'b0);
    t_i2c;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    tally_and_finish;
  end
endmodule : ccc_regs_tb_top
bind ccc_regs ccc_regs_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .i2c_req_valid(i2c_req_valid),
  .i2c_req_write(i2c_req_write), .fwd_lock(fwd_lock), .remote_ack(remote_ack),
  .fwd_valid(fwd_valid), .i2c_ack_valid(i2c_ack_valid), .i2c_ack(i2c_ack),
  .bc_rx_valid(bc_rx_valid), .bc_rx_data(bc_rx_data), .bc_rx_parity(bc_rx_parity),
  .parity_err_pulse(parity_err_pulse), .seq_valid(seq_valid), .crc_valid(crc_valid),
  .fwd_gpio_lanes(fwd_gpio_lanes));
`default_nettype wire
